// ===== design/prioritized_irq_controller.sv
// Vectored, prioritized interrupt controller with Avalon-MM register slave
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module prioritized_irq_controller
  import irq_ctrl_pkg::*;
#(
  parameter int N = NUM_SOURCES,
  parameter int NEST = NEST_DEPTH
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [N-1:0] src_irq,
  input wire logic nmi_pin,
  output logic core_irq_req,
  output logic [31:0] core_vector,
  output logic [$clog2(N)-1:0] core_src_id,
  input wire logic core_ack,
  input wire logic core_return,
  output logic core_nmi_req,
  output logic core_thread_ok,
  output logic evt_irq
);

  localparam int IDW = $clog2(N);
  localparam int NW = $clog2(NEST);
  localparam int DW = NW + 1;

  // Whole controller state, registered in one place
  typedef struct packed {
    logic [N-1:0] src_m;                   // First sync stage, read by src_s only
    logic [N-1:0] src_s;
    logic nmi_m;
    logic nmi_s;
    logic nmi_p;                           // Delayed second stage for edge detect
    logic [N-1:0] en;                      // Per-source enables
    logic gate;                            // Global gate, 1 = open
    logic [2:0] split;                     // Preemption bit count as written
    logic [31-VTABLE_ALIGN_BITS:0] vtbase; // Table base above the 1 kB line
    logic [N-1:0][PRIO_BITS-1:0] prio;     // Implemented priority bits only
    logic [N-1:0] active;                  // Sources with a handler on the stack
    logic [DW-1:0] depth;                  // Nesting depth
    logic [NEST-1:0][IDW-1:0] stk_id;
    logic [NEST-1:0][PRIO_BITS-1:0] stk_lvl;
    logic req;
    logic [IDW-1:0] id;
    logic [31:0] vec;
    logic thread;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic done;                            // Bus answer cycle
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Preemption group of a priority under a given split
  function automatic logic [PRIO_BITS-1:0] preempt_key(
    input logic [PRIO_BITS-1:0] pri,
    input logic [2:0] split
  );
    logic [2:0] p;
    p = (split > 3'(PRIO_BITS)) ? 3'(PRIO_BITS) : split;
    return pri >> (3'(PRIO_BITS) - p);
  endfunction

  // Merge write data under the byte enables
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic: sync, arbitration, nesting stack, bus
  always_comb
  begin
    logic [N-1:0] pend;
    logic best_ok;
    logic [IDW-1:0] best_id;
    logic [PRIO_BITS-1:0] best_pri;
    logic [PRIO_BITS-1:0] top_lvl;
    logic beats;
    logic [DW-1:0] dep;
    logic [NW-1:0] slot;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [31:0] wmask;
    logic [31:0] rd;
    logic wr_now;
    logic [IDW-1:0] pidx;
    logic [31:0] vt_new;
    pend = '0;
    best_ok = 1'b0;
    best_id = '0;
    best_pri = '1;
    top_lvl = '1;
    beats = 1'b0;
    dep = s_q.depth;
    slot = '0;
    evt_set = '0;
    evt_clr = '0;
    wmask = '0;
    rd = '0;
    wr_now = 1'b0;
    pidx = avs_address[IDW+1:2];
    vt_new = '0;
    s_d = s_q;

    // Two-stage synchronisers for the asynchronous source pins
    s_d.src_m = src_irq;
    s_d.src_s = s_q.src_m;
    s_d.nmi_m = nmi_pin;
    s_d.nmi_s = s_q.nmi_m;
    s_d.nmi_p = s_q.nmi_s;
    // The non-maskable path bypasses the gate entirely
    // Edge taken after the second stage so a metastable first stage is never read
    if (s_q.nmi_s && !s_q.nmi_p)
    begin
      evt_set[EVT_NMI] = 1'b1;
    end

    // Controller enable only; the peripheral's own enable is untouched
    pend = s_q.src_s & s_q.en & ~s_q.active;
    // Ascending scan with strict compare keeps the lower number on a tie
    for (int i = 0; i < N; i++)
    begin
      if (pend[i] && (!best_ok || s_q.prio[i] < best_pri))
      begin
        best_ok = 1'b1;
        best_id = IDW'(i);
        best_pri = s_q.prio[i];
      end
    end

    // Current running level, if any
    if (s_q.depth != '0)
    begin
      slot = NW'(s_q.depth - DW'(1));
      top_lvl = s_q.stk_lvl[slot];
    end
    // Only a strictly better preemption group interrupts a handler
    beats = best_ok && ((s_q.depth == '0) ||
      (preempt_key(best_pri, s_q.split) < top_lvl));

    // Handler return pops the stack first
    if (core_return && (dep != '0))
    begin
      slot = NW'(dep - DW'(1));
      s_d.active[s_q.stk_id[slot]] = 1'b0;
      dep = dep - DW'(1);
      // Any pending request flags tail chaining, even one the gate or the level still on the stack holds back
      if (best_ok)
      begin
        evt_set[EVT_TAIL] = 1'b1;
      end
    end
    // Acceptance pushes the offered source
    if (core_ack && s_q.req && (dep != DW'(NEST)))
    begin
      slot = NW'(dep);
      s_d.stk_id[slot] = s_q.id;
      s_d.stk_lvl[slot] = preempt_key(s_q.prio[s_q.id], s_q.split);
      s_d.active[s_q.id] = 1'b1;
      dep = dep + DW'(1);
      evt_set[EVT_DISPATCH] = 1'b1;
    end
    s_d.depth = dep;
    s_d.thread = (dep == '0) && (pend == '0);

    // Offer drops for one cycle after acceptance so it is not taken twice
    s_d.req = s_q.gate && beats && !(core_ack && s_q.req);
    s_d.id = best_id;
    s_d.vec = {s_q.vtbase, 10'h000} +
      {22'h000000, 8'(best_id) + VEC_FIRST_ENTRY, 2'b00};

    // Bus: one wait cycle, then the answer
    s_d.done = (avs_read || avs_write) && !s_q.done;
    wr_now = avs_write && s_q.done;
    wmask = be_merge(32'h00000000, 32'hffffffff, avs_byteenable);

    // Read mux, captured in the wait cycle
    if (avs_address[PRIO_REGION_BIT])
    begin
      rd = {24'h000000, s_q.prio[pidx], 5'h00};
    end
    else
    begin
      unique case (avs_address)
        OFS_ENABLE, OFS_EN_SET, OFS_EN_CLR: rd = 32'(s_q.en);
        OFS_GATE: rd = {31'h00000000, s_q.gate};
        OFS_SPLIT: rd = {29'h00000000, s_q.split};
        OFS_CORE_STAT:
        begin
          rd = 32'(s_q.stk_id[NW'(s_q.depth - DW'(1))]);
          rd[STAT_DEPTH_LSB +: DW] = s_q.depth;
          rd[STAT_THREAD_BIT] = s_q.thread;
        end
        OFS_EVT_STAT: rd = 32'(s_q.evt);
        OFS_EVT_MASK: rd = 32'(s_q.mask);
        OFS_VTABLE: rd = {s_q.vtbase, 10'h000};
        // Unmapped words read as zero
        default: rd = 32'h00000000;
      endcase
    end
    if (avs_read && !s_q.done)
    begin
      s_d.rdata = rd;
    end

    // Writes take effect on the answer edge only
    if (wr_now)
    begin
      if (avs_address[PRIO_REGION_BIT])
      begin
        if (avs_byteenable[0])
        begin
          // Low bits are dropped: hardware ignores them
          s_d.prio[pidx] = avs_writedata[PRIO_FIELD_LSB +: PRIO_BITS];
        end
      end
      else
      begin
        unique case (avs_address)
          OFS_ENABLE: s_d.en = N'(be_merge(32'(s_q.en), avs_writedata, avs_byteenable));
          OFS_EN_SET: s_d.en = s_q.en | N'(avs_writedata & wmask);
          OFS_EN_CLR: s_d.en = s_q.en & ~N'(avs_writedata & wmask);
          OFS_GATE:
          begin
            // Close wins when both bits are written
            if (avs_byteenable[0] && avs_writedata[GATE_OPEN_BIT])
            begin
              s_d.gate = 1'b1;
            end
            if (avs_byteenable[0] && avs_writedata[GATE_CLOSE_BIT])
            begin
              s_d.gate = 1'b0;
            end
          end
          OFS_SPLIT:
          begin
            if (avs_byteenable[0])
            begin
              s_d.split = avs_writedata[2:0];
            end
          end
          OFS_EVT_STAT: evt_clr = EVT_W'(avs_writedata & wmask);
          OFS_EVT_MASK: s_d.mask = EVT_W'(be_merge(32'(s_q.mask), avs_writedata, avs_byteenable));
          // Low ten bits are forced to zero so the base stays aligned
          OFS_VTABLE:
          begin
            vt_new = be_merge({s_q.vtbase, 10'h000}, avs_writedata, avs_byteenable);
            s_d.vtbase = vt_new[31:VTABLE_ALIGN_BITS];
          end
          default:
          begin
            // Unmapped writes are dropped
          end
        endcase
      end
    end
    // Set beats clear in the same cycle
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.split <= RST_SPLIT;
      s_q.thread <= RST_THREAD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.done;
  assign avs_readdata = s_q.rdata;
  assign core_irq_req = s_q.req;
  assign core_vector = s_q.vec;
  assign core_src_id = s_q.id;
  assign core_nmi_req = s_q.nmi_s;
  assign core_thread_ok = s_q.thread;
  // Level output while any unmasked event bit is set
  assign evt_irq = |(s_q.evt & s_q.mask);

  // Gate closed means no offer on the next cycle
  chk_gate_blocks: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.gate |=> !core_irq_req)
    else $error("request raised while gate closed");

  // Non-maskable path through two stages, gate ignored
  chk_nmi_passes: assert property (@(posedge ref_clk) disable iff (!nrst)
    nmi_pin ##1 nmi_pin |=> core_nmi_req)
    else $error("nmi not forwarded after two stages");

  // Vector is base plus entry of the offered source
  chk_vector_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
    core_irq_req |-> (core_vector[31:VTABLE_ALIGN_BITS] == $past(s_q.vtbase)) &&
      (core_vector[9:2] == 8'(core_src_id) + VEC_FIRST_ENTRY) &&
      (core_vector[1:0] == 2'b00))
    else $error("vector address wrong");

  // Offered source was enabled and not active
  chk_req_enabled: assert property (@(posedge ref_clk) disable iff (!nrst)
    core_irq_req |-> |($past(s_q.en & ~s_q.active) & (N'(1) << core_src_id)))
    else $error("request from disabled or active source");

  // Acceptance deepens nesting by one and drops the offer
  chk_ack_push: assert property (@(posedge ref_clk) disable iff (!nrst)
    core_ack && core_irq_req && !core_return |=>
      (s_q.depth == $past(s_q.depth) + DW'(1)) && !core_irq_req)
    else $error("accept did not push");

  // Each nested level strictly more urgent than the one below
  chk_nest_strict: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.depth > DW'(1) |-> s_q.stk_lvl[NW'(s_q.depth - DW'(1))] <
      s_q.stk_lvl[NW'(s_q.depth - DW'(2))])
    else $error("nesting order broken");

  // Grouping holds the written count for readback
  chk_split_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    avs_write && !avs_waitrequest && avs_address == OFS_SPLIT && avs_byteenable[0] |=>
      s_q.split == $past(avs_writedata[2:0]))
    else $error("grouping readback differs");

  // Thread indication only with empty stack
  chk_thread_empty: assert property (@(posedge ref_clk) disable iff (!nrst)
    core_thread_ok |-> s_q.depth == '0)
    else $error("thread indicated while nested");

endmodule

`default_nettype wire

// ===== design/irq_ctrl_pkg.sv
// Constants shared by the prioritized interrupt controller
package irq_ctrl_pkg;

  // Sizes of the controller
  localparam int NUM_SOURCES = 32;
  localparam int PRIO_BITS = 3;
  localparam int NEST_DEPTH = 8;
  localparam int EVT_W = 3;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_EN_SET = 8'h04;
  localparam logic [7:0] OFS_EN_CLR = 8'h08;
  localparam logic [7:0] OFS_GATE = 8'h0c;
  localparam logic [7:0] OFS_SPLIT = 8'h10;
  localparam logic [7:0] OFS_CORE_STAT = 8'h14;
  localparam logic [7:0] OFS_EVT_STAT = 8'h18;
  localparam logic [7:0] OFS_EVT_MASK = 8'h1c;
  localparam logic [7:0] OFS_VTABLE = 8'h20;
  // Priority words sit at 8'h80 + 4 * source
  localparam int PRIO_REGION_BIT = 7;

  // Field positions
  localparam int GATE_OPEN_BIT = 0;
  localparam int GATE_CLOSE_BIT = 1;
  localparam int PRIO_FIELD_LSB = 5;
  localparam int STAT_DEPTH_LSB = 8;
  localparam int STAT_THREAD_BIT = 16;
  localparam int VTABLE_ALIGN_BITS = 10;
  localparam int EVT_DISPATCH = 0;
  localparam int EVT_TAIL = 1;
  localparam int EVT_NMI = 2;

  // First table entry used by source 0
  localparam logic [7:0] VEC_FIRST_ENTRY = 8'h10;

  // Values after reset
  localparam logic [2:0] RST_SPLIT = 3'h7;
  localparam logic RST_THREAD = 1'b1;

endpackage

// ===== tb/core_model.sv
// Behavioural processor core that takes offers and ends handlers
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic core_irq_req,
  input wire logic ack_en,
  input wire logic ret_go,
  output logic core_ack,
  output logic core_return
);
  int depth; // Handlers in progress
  // One-cycle accept while offered, one-cycle end on command
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      core_ack <= 1'b0;
      core_return <= 1'b0;
      depth <= 0;
    end
    else
    begin
      // Bench installs handlers before it enables sources
      core_ack <= ack_en && core_irq_req && !core_ack;
      // Never ends a handler at thread level
      core_return <= ret_go && depth > 0;
      depth <= depth + int'(core_ack && core_irq_req) - int'(core_return);
    end
endmodule
`default_nettype wire

// ===== tb/prioritized_irq_controller_tb.sv
// Self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module prioritized_irq_controller_tb;
  import irq_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] src_irq = 32'h0;
  logic nmi_pin = 1'b0;
  logic core_irq_req, core_ack, core_return, core_nmi_req, core_thread_ok, evt_irq;
  logic [31:0] core_vector;
  logic [4:0] core_src_id;
  logic ack_en = 1'b0; // Core accepts offers
  logic ret_go = 1'b0; // Core ends innermost handler
  logic [31:0] rd; // Last read data
  logic [4:0] tid; // Last accepted source
  logic [31:0] vbase = 32'h400; // Aligned table base
  int error_cnt = 0;
  int n_tests = 0;

  // Free-running clock, 8 ns period
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  prioritized_irq_controller DUT (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_irq(src_irq), .nmi_pin(nmi_pin),
    .core_irq_req(core_irq_req), .core_vector(core_vector), .core_src_id(core_src_id),
    .core_ack(core_ack), .core_return(core_return), .core_nmi_req(core_nmi_req),
    .core_thread_ok(core_thread_ok), .evt_irq(evt_irq));

  core_model core (.ref_clk(ref_clk), .nrst(nrst), .core_irq_req(core_irq_req),
    .ack_en(ack_en), .ret_go(ret_go), .core_ack(core_ack), .core_return(core_return));

  // Verdict and end of run
  task test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Avalon transfer held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 20)
    begin
      error_cnt++;
      test_done();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Wait for the core to accept an offer; vector must match the id
  task automatic wait_take;
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      if (core_ack === 1'b1 && core_irq_req === 1'b1)
        break;
    end
    if (i == 40)
    begin
      error_cnt++;
      test_done();
    end
    tid = core_src_id;
    `CHK(core_vector, vbase + {core_src_id, 2'b00} + 32'(VEC_FIRST_ENTRY) * 4)
  endtask

  // Core ends the innermost handler
  task ret;
    @(posedge ref_clk);
    ret_go <= 1'b1;
    @(posedge ref_clk);
    ret_go <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Reset values and register fields
  task t_regs;
    bus(0, OFS_SPLIT, 0);
    `CHK(rd[2:0], RST_SPLIT)
    bus(0, OFS_CORE_STAT, 0);
    `CHK(rd[STAT_THREAD_BIT], RST_THREAD)
    bus(0, 8'h40, 0);
    `CHK(rd, 32'h0) // Unmapped place reads zero
    bus(1, OFS_SPLIT, 32'h3);
    bus(0, OFS_SPLIT, 0);
    `CHK(rd[2:0], 3'h3)
    bus(1, OFS_SPLIT, 32'h7);
    bus(1, 8'h8c, 32'hff);
    bus(0, 8'h8c, 0);
    `CHK(rd, 32'he0)
    bus(1, OFS_VTABLE, 32'h7ff);
    bus(0, OFS_VTABLE, 0);
    `CHK(rd, vbase)
    bus(1, OFS_EN_SET, 32'h8);
    $display("t_regs done");
  endtask

  // Gate blocks only the request line; non-maskable passes
  task t_gate;
    src_irq[3] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK(core_irq_req, 1'b0)
    ack_en <= 1'b1;
    bus(1, OFS_GATE, 32'h1);
    wait_take();
    `CHK(tid, 5'd3)
    src_irq[3] <= 1'b0;
    bus(1, OFS_GATE, 32'h2);
    bus(0, OFS_ENABLE, 0);
    `CHK(rd, 32'h8)
    nmi_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(core_nmi_req, 1'b1)
    nmi_pin <= 1'b0;
    ret();
    $display("t_gate done");
  endtask

  // Ties, urgency, preemption, nesting and tail chaining
  task t_prio;
    bus(1, OFS_EN_SET, 32'h0010_0220);
    bus(1, 8'h94, 32'h40);
    bus(1, 8'ha4, 32'h40);
    bus(1, 8'hd0, 32'h20);
    bus(1, OFS_GATE, 32'h1);
    src_irq[5] <= 1'b1;
    src_irq[9] <= 1'b1;
    wait_take();
    `CHK(tid, 5'd5)
    src_irq[5] <= 1'b0;
    src_irq[20] <= 1'b1;
    wait_take();
    `CHK(tid, 5'd20)
    src_irq[20] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(core_thread_ok, 1'b0)
    // Core holds off so the tail-chained offer stands until it is looked for
    ack_en <= 1'b0;
    ret();
    ret();
    ack_en <= 1'b1;
    wait_take();
    `CHK(tid, 5'd9)
    src_irq[9] <= 1'b0;
    ret();
    `CHK(core_thread_ok, 1'b1)
    $display("t_prio done");
  endtask

  // Grouping zero: a more urgent source waits for the tail
  task t_split0;
    bus(1, OFS_SPLIT, 32'h0);
    bus(1, OFS_EN_SET, 32'h4000_0000);
    src_irq[5] <= 1'b1;
    wait_take();
    src_irq[5] <= 1'b0;
    src_irq[30] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK(core_irq_req, 1'b0)
    ack_en <= 1'b0;
    ret();
    ack_en <= 1'b1;
    wait_take();
    `CHK(tid, 5'd30)
    src_irq[30] <= 1'b0;
    ret();
    $display("t_split0 done");
  endtask

  // Event status, mask and write-one-to-clear
  task t_evt;
    bus(0, OFS_EVT_STAT, 0);
    `CHK(rd[2:0], 3'h7) // Dispatch, tail and nmi seen
    `CHK(evt_irq, 1'b0) // Masked
    bus(1, OFS_EVT_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(evt_irq, 1'b1) // Unmasked dispatch
    bus(1, OFS_EVT_STAT, 32'h7);
    bus(0, OFS_EVT_STAT, 0);
    `CHK(rd, 32'h0) // Cleared
    `CHK(evt_irq, 1'b0) // Line drops
    $display("t_evt done");
  endtask

  // Reset for four cycles, then every scenario
  initial
  begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_gate();
    t_prio();
    t_split0();
    t_evt();
    test_done();
  end
endmodule
`default_nettype wire
